// >>> core/ubg_consts.svh
`ifndef UBG_CONSTS_SVH
`define UBG_CONSTS_SVH

// special-register decode: page and address of each register
`define UBG_PAGE_DATA 8'h00
`define UBG_ADDR_DATA 8'h99
`define UBG_PAGE_BAUD 8'h0f
`define UBG_ADDR_CTRL 8'hab
`define UBG_ADDR_RLL 8'hac
`define UBG_ADDR_RLH 8'had

// control register fields
`define UBG_RUN_BIT 6
`define UBG_PS_MSB 1
`define UBG_PS_LSB 0

// reset values
`define UBG_RST_DATA 8'h00
`define UBG_RST_CTRL 8'h00
`define UBG_RST_RLL 8'h00
`define UBG_RST_RLH 8'h00

// prescaler divide ratios per select code
`define UBG_DIV_PS0 6'd12
`define UBG_DIV_PS1 6'd4
`define UBG_DIV_PS2 6'd48
`define UBG_DIV_PS3 6'd1

// baud counter wrap point
`define UBG_CNT_MAX 16'hffff

// baud ticks per serial bit time
`define UBG_TICKS_PER_BIT 2

`endif

// >>> core/ubg_pkg.sv
`default_nettype none

package ubg_pkg;

    typedef enum logic [3:0] {
        UBG_TX_IDLE  = 4'b0001,
        UBG_TX_START = 4'b0010,
        UBG_TX_DATA  = 4'b0100,
        UBG_TX_STOP  = 4'b1000
    } ubg_tx_state_t;

    typedef enum logic [3:0] {
        UBG_RX_IDLE  = 4'b0001,
        UBG_RX_START = 4'b0010,
        UBG_RX_DATA  = 4'b0100,
        UBG_RX_STOP  = 4'b1000
    } ubg_rx_state_t;

    typedef struct packed {
        logic [5:0] cnt;
        logic tick;
    } ubg_ps_state_t;

    typedef struct packed {
        logic run;
        logic [1:0] ps_sel;
        logic [7:0] rld_lo;
        logic [7:0] rld_hi;
        logic [15:0] cnt;
        logic tick;
        ubg_tx_state_t tx_st;
        logic [7:0] tx_shift;
        logic [2:0] tx_bit;
        logic [3:0] tx_sub;
        logic txd;
        logic tx_busy;
        ubg_rx_state_t rx_st;
        logic [7:0] rx_shift;
        logic [2:0] rx_bit;
        logic [3:0] rx_sub;
        logic [7:0] rx_latch;
        logic rx_valid;
        logic rxd_prev;
        logic [7:0] rdata;
    } ubg_state_t;

endpackage

`default_nettype wire

// >>> core/ubg_prescaler.sv
`include "ubg_consts.svh"
`default_nettype none

module ubg_prescaler
    import ubg_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_run,
    input wire logic [1:0] i_sel,
    output logic o_tick
);

    ubg_ps_state_t q;
    ubg_ps_state_t d;

    // divide ratio for a select code
    function automatic logic [5:0] ps_div(input logic [1:0] sel);
        unique case (sel)
            2'b00: ps_div = `UBG_DIV_PS0;
            2'b01: ps_div = `UBG_DIV_PS1;
            2'b10: ps_div = `UBG_DIV_PS2;
            2'b11: ps_div = `UBG_DIV_PS3;
        endcase
    endfunction

    // one tick every ps_div input clocks while running
    always_comb begin
        d = q;
        if (i_ce) begin
            d.tick = 1'b0;
            if (!i_run) begin
                d.cnt = 6'h00; // stopped generator clears prescaler
            end else if (q.cnt >= ps_div(i_sel) - 6'h01) begin
                d.cnt = 6'h00;
                d.tick = 1'b1;
            end else begin
                d.cnt = q.cnt + 6'h01;
            end
        end
    end

    // state register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_tick = q.tick;

endmodule

`default_nettype wire

// >>> core/ubg_uart_core.sv
`include "ubg_consts.svh"
`default_nettype none

module ubg_uart_core
    import ubg_pkg::*;
#(
    parameter int TICKS_PER_BIT = `UBG_TICKS_PER_BIT
)
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [7:0] i_sfr_page,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    output logic [7:0] o_sfr_rdata,
    input wire logic i_rxd,
    output logic o_txd,
    output logic o_tx_busy,
    output logic o_rx_valid,
    output logic o_baud_tick
);

    localparam logic [3:0] TPB = 4'(TICKS_PER_BIT);
    localparam logic [3:0] HALF = 4'(TICKS_PER_BIT / 2);

    ubg_state_t q;
    ubg_state_t d;
    logic ps_tick;
    logic [7:0] ctrl_rd;
    logic wr_ok;
    logic rd_ok;
    logic sel_data;
    logic sel_ctrl;
    logic sel_rll;
    logic sel_rlh;
    logic tx_load;
    logic rx_fall;
    logic cnt_step;
    logic cnt_ovf;

    // true when page and address hit a given register
    function automatic logic sfr_hit(
        input logic [7:0] page,
        input logic [7:0] addr,
        input logic [7:0] want_page,
        input logic [7:0] want_addr
    );
        sfr_hit = (page == want_page) && (addr == want_addr);
    endfunction

    // last baud tick of one bit time
    function automatic logic bit_end(input logic [3:0] sub);
        bit_end = (sub == TPB - 4'h1);
    endfunction

    // prescaler feeding the reload counter
    ubg_prescaler u_prescaler (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_run(q.run),
        .i_sel(q.ps_sel),
        .o_tick(ps_tick)
    );

    // control readback with reserved bits forced low
    always_comb begin
        ctrl_rd = 8'h00;
        ctrl_rd[`UBG_RUN_BIT] = q.run;
        ctrl_rd[`UBG_PS_MSB:`UBG_PS_LSB] = q.ps_sel;
    end

    // accepted strobes and one select per register
    always_comb begin
        wr_ok = i_ce && i_sfr_wr;
        rd_ok = i_ce && i_sfr_rd;
        sel_data = sfr_hit(i_sfr_page, i_sfr_addr,
            `UBG_PAGE_DATA, `UBG_ADDR_DATA);
        sel_ctrl = sfr_hit(i_sfr_page, i_sfr_addr,
            `UBG_PAGE_BAUD, `UBG_ADDR_CTRL);
        sel_rll = sfr_hit(i_sfr_page, i_sfr_addr,
            `UBG_PAGE_BAUD, `UBG_ADDR_RLL);
        sel_rlh = sfr_hit(i_sfr_page, i_sfr_addr,
            `UBG_PAGE_BAUD, `UBG_ADDR_RLH);
        tx_load = wr_ok && sel_data;
    end

    // a prescaled clock while running steps the reload counter
    assign cnt_step = q.run && ps_tick;
    assign cnt_ovf = (q.cnt == `UBG_CNT_MAX);

    // start edge on the receive line, only while the generator runs
    assign rx_fall = q.run && q.rxd_prev && !i_rxd;

    // next-state logic for the whole block
    always_comb begin
        d = q;
        if (i_ce) begin
            d.tick = 1'b0;
            d.rx_valid = 1'b0;
            d.rxd_prev = i_rxd;

            // register writes
            if (wr_ok) begin
                if (sel_ctrl) begin
                    d.run = i_sfr_wdata[`UBG_RUN_BIT];
                    d.ps_sel = i_sfr_wdata[`UBG_PS_MSB:`UBG_PS_LSB];
                end
                if (sel_rll) begin
                    d.rld_lo = i_sfr_wdata;
                end
                if (sel_rlh) begin
                    d.rld_hi = i_sfr_wdata;
                end
            end

            // register reads, registered; unmapped reads give zero
            if (rd_ok) begin
                d.rdata = 8'h00;
                if (sel_data) begin
                    d.rdata = q.rx_latch;
                end
                if (sel_ctrl) begin
                    d.rdata = ctrl_rd;
                end
                if (sel_rll) begin
                    d.rdata = q.rld_lo;
                end
                if (sel_rlh) begin
                    d.rdata = q.rld_hi;
                end
            end

            // reload counter: count on prescaled clock, reload on overflow
            if (cnt_step) begin
                if (cnt_ovf) begin
                    d.cnt[15:8] = q.rld_hi;
                    d.cnt[7:0] = q.rld_lo;
                    d.tick = 1'b1;
                end else begin
                    d.cnt = q.cnt + 16'h0001;
                end
            end

            // transmitter: advances one bit every TPB baud ticks
            unique case (q.tx_st)
                UBG_TX_IDLE: begin
                    d.txd = 1'b1;
                end
                UBG_TX_START: begin
                    if (q.tick) begin
                        if (bit_end(q.tx_sub)) begin
                            d.tx_sub = 4'h0;
                            d.tx_bit = 3'h0;
                            d.txd = q.tx_shift[0];
                            d.tx_st = UBG_TX_DATA;
                        end else begin
                            d.tx_sub = q.tx_sub + 4'h1;
                        end
                    end
                end
                UBG_TX_DATA: begin
                    if (q.tick) begin
                        if (bit_end(q.tx_sub)) begin
                            d.tx_sub = 4'h0;
                            if (q.tx_bit == 3'h7) begin
                                d.txd = 1'b1;
                                d.tx_st = UBG_TX_STOP;
                            end else begin
                                d.tx_bit = q.tx_bit + 3'h1;
                                d.txd = q.tx_shift[q.tx_bit + 3'h1];
                            end
                        end else begin
                            d.tx_sub = q.tx_sub + 4'h1;
                        end
                    end
                end
                UBG_TX_STOP: begin
                    if (q.tick) begin
                        if (bit_end(q.tx_sub)) begin
                            d.tx_sub = 4'h0;
                            d.tx_busy = 1'b0;
                            d.tx_st = UBG_TX_IDLE;
                        end else begin
                            d.tx_sub = q.tx_sub + 4'h1;
                        end
                    end
                end
                default: begin
                    d.txd = 1'b1;
                    d.tx_busy = 1'b0;
                    d.tx_st = UBG_TX_IDLE;
                end
            endcase

            // a data write loads and holds the byte and starts a frame
            if (tx_load) begin
                d.tx_shift = i_sfr_wdata;
                d.tx_st = UBG_TX_START;
                d.tx_sub = 4'h0;
                d.tx_bit = 3'h0;
                d.txd = 1'b0;
                d.tx_busy = 1'b1;
            end

            // receiver: start edge, mid-bit sampling, latch on good stop
            unique case (q.rx_st)
                UBG_RX_IDLE: begin
                    if (rx_fall) begin
                        d.rx_sub = 4'h0;
                        d.rx_st = UBG_RX_START;
                    end
                end
                UBG_RX_START: begin
                    if (q.tick) begin
                        if (q.rx_sub + 4'h1 >= HALF) begin
                            d.rx_sub = 4'h0;
                            d.rx_bit = 3'h0;
                            // a start bit gone high again was a glitch
                            d.rx_st = i_rxd ? UBG_RX_IDLE : UBG_RX_DATA;
                        end else begin
                            d.rx_sub = q.rx_sub + 4'h1;
                        end
                    end
                end
                UBG_RX_DATA: begin
                    if (q.tick) begin
                        if (bit_end(q.rx_sub)) begin
                            d.rx_sub = 4'h0;
                            d.rx_shift[q.rx_bit] = i_rxd;
                            if (q.rx_bit == 3'h7) begin
                                d.rx_st = UBG_RX_STOP;
                            end else begin
                                d.rx_bit = q.rx_bit + 3'h1;
                            end
                        end else begin
                            d.rx_sub = q.rx_sub + 4'h1;
                        end
                    end
                end
                UBG_RX_STOP: begin
                    if (q.tick) begin
                        if (bit_end(q.rx_sub)) begin
                            d.rx_sub = 4'h0;
                            d.rx_st = UBG_RX_IDLE;
                            if (i_rxd) begin
                                d.rx_latch = q.rx_shift;
                                d.rx_valid = 1'b1;
                            end
                        end else begin
                            d.rx_sub = q.rx_sub + 4'h1;
                        end
                    end
                end
                default: begin
                    d.rx_st = UBG_RX_IDLE;
                end
            endcase
        end
    end

    // state register; clears to zero at reset except txd, rxd_prev and the one-hot states
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            q <= '0;
            q.rld_lo <= `UBG_RST_RLL;
            q.rld_hi <= `UBG_RST_RLH;
            q.rx_latch <= `UBG_RST_DATA;
            q.tx_shift <= `UBG_RST_DATA;
            q.tx_st <= UBG_TX_IDLE;
            q.rx_st <= UBG_RX_IDLE;
            q.txd <= 1'b1; // idle line is high
            q.rxd_prev <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign o_sfr_rdata = q.rdata;
    assign o_txd = q.txd;
    assign o_tx_busy = q.tx_busy;
    assign o_rx_valid = q.rx_valid;
    assign o_baud_tick = q.tick;

endmodule

`default_nettype wire

// >>> testbench/ubg_uart_checker.sv
`default_nettype none

module ubg_uart_checker (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [7:0] i_sfr_page,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic [7:0] o_sfr_rdata,
    input wire logic i_rxd,
    input wire logic o_txd,
    input wire logic o_tx_busy,
    input wire logic o_rx_valid,
    input wire logic o_baud_tick
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rd, wr, pg_f, mapped, run_q;
    logic [7:0] rll_q;

    // accepted strobes and address decode
    assign rd = i_sfr_rd & i_ce;
    assign wr = i_sfr_wr & i_ce;
    assign pg_f = i_sfr_page == 8'h0f;
    assign mapped = (i_sfr_page == 8'h00 && i_sfr_addr == 8'h99)
        || (pg_f && i_sfr_addr inside {8'hab, 8'hac, 8'had});

    // shadow of the generator run bit
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            run_q <= 1'b0;
        end else if (wr && pg_f && i_sfr_addr == 8'hab) begin
            run_q <= i_sfr_wdata[6];
        end
    end

    // shadow of the reload low register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rll_q <= 8'h00;
        end else if (wr && pg_f && i_sfr_addr == 8'hac) begin
            rll_q <= i_sfr_wdata;
        end
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_unmapped_zero: assert property (
        rd && !mapped |=> o_sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_ctrl_reserved: assert property (
        rd && pg_f && i_sfr_addr == 8'hab |=> (o_sfr_rdata & 8'hbc) == 8'h00)
        else $error("reserved control bits not zero");
    a_rdata_holds: assert property (
        !rd |=> $stable(o_sfr_rdata))
        else $error("read data changed without read");
    a_tx_starts: assert property (
        wr && i_sfr_page == 8'h00 && i_sfr_addr == 8'h99
        |=> !o_txd && o_tx_busy)
        else $error("data write did not start frame");
    a_reload_lo_rb: assert property (
        rd && pg_f && i_sfr_addr == 8'hac |=> o_sfr_rdata == $past(rll_q))
        else $error("reload low readback wrong");
    a_stopped_quiet: assert property (
        !run_q && !$past(run_q, 3) |-> !o_baud_tick)
        else $error("baud tick while stopped");
    a_idle_high: assert property (
        !o_tx_busy |-> o_txd)
        else $error("transmit line low while idle");
    a_rx_pulse: assert property (
        o_rx_valid && i_ce |=> !o_rx_valid)
        else $error("receive pulse longer than one cycle");

    c_unmapped: cover property (rd && !mapped);
    c_rx_byte: cover property (o_rx_valid);
    c_tx_done: cover property ($fell(o_tx_busy));
    c_reload_rd: cover property (rd && pg_f && i_sfr_addr == 8'hac);
endmodule

bind ubg_uart_core ubg_uart_checker ubg_uart_checker_i (
    .i_clk, .i_rst, .i_ce, .i_sfr_page, .i_sfr_addr, .i_sfr_wr, .i_sfr_rd,
    .i_sfr_wdata, .o_sfr_rdata, .i_rxd, .o_txd, .o_tx_busy, .o_rx_valid,
    .o_baud_tick
);

`default_nettype wire

// >>> testbench/ubg_remote_port.sv
`default_nettype none

module ubg_remote_port #(
    parameter int BIT_CLKS = 8
) (
    input wire logic i_clk,
    output logic o_rxd
);
    timeunit 1ns;
    timeprecision 1ps;

    // line idles high between frames
    initial o_rxd = 1'b1;

    // one frame, lsb first; caller picks the stop level
    task automatic send(input logic [7:0] b, input logic stop);
        logic [9:0] f;
        f = {stop, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            o_rxd = f[i];
            repeat (BIT_CLKS) @(negedge i_clk);
        end
        o_rxd = 1'b1;
    endtask
endmodule

`default_nettype wire

// >>> testbench/tb.sv
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, ce, wr, rd, rxd, txd, busy, rxv, tick;
    logic [7:0] page, addr, wdata, rdata, b0, b1;
    logic [19:0] smp;
    int fail_count, n_checks, cyc, nrx;
    int divs[4] = '{12, 4, 48, 1};
    int sels[4] = '{3, 1, 0, 2};

    ubg_uart_core #(.TICKS_PER_BIT(2)) ubg_uart_core_i (
        .i_clk(clk), .i_rst(rst), .i_ce(ce), .i_sfr_page(page),
        .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_rd(rd),
        .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_rxd(rxd),
        .o_txd(txd), .o_tx_busy(busy), .o_rx_valid(rxv),
        .o_baud_tick(tick)
    );

    ubg_remote_port #(.BIT_CLKS(8)) ubg_remote_port_i (
        .i_clk(clk),
        .o_rxd(rxd)
    );

    // system clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // count received-byte pulses
    always @(negedge clk) begin
        if (rxv === 1'b1) nrx++;
    end

    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one strobe cycle on the register bus
    task automatic acc(input logic w, input logic [7:0] p, a, d);
        @(negedge clk);
        page = p;
        addr = a;
        wdata = d;
        wr = w;
        rd = !w;
        @(negedge clk);
        wr = 1'b0;
        rd = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] p, a, exp);
        acc(1'b0, p, a, 8'h00);
        check(rdata, exp);
    endtask

    // cycles up to the next baud tick, bounded
    task automatic wait_tick(input int lim);
        cyc = 0;
        do begin
            @(negedge clk);
            cyc++;
        end while (tick !== 1'b1 && cyc < lim);
        if (tick !== 1'b1) begin
            fail_count++;
            $display("ERROR %0t no baud tick", $time);
            conclude();
        end
    endtask

    // main sequence
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        page = 8'h00;
        addr = 8'h00;
        wdata = 8'h00;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        rd_chk(8'h00, 8'h99, 8'h00);
        rd_chk(8'h0f, 8'hab, 8'h00);
        rd_chk(8'h0f, 8'hac, 8'h00);
        rd_chk(8'h0f, 8'had, 8'h00);
        acc(1'b1, 8'h0f, 8'hac, 8'hfc);
        acc(1'b1, 8'h0f, 8'had, 8'hff);
        rd_chk(8'h0f, 8'hac, 8'hfc);
        rd_chk(8'h0f, 8'had, 8'hff);
        rd_chk(8'h00, 8'hac, 8'h00);
        rd_chk(8'h0f, 8'h99, 8'h00);
        acc(1'b1, 8'h0f, 8'hab, 8'h03);
        rd_chk(8'h0f, 8'hab, 8'h03);
        ce = 1'b0;
        acc(1'b1, 8'h0f, 8'hac, 8'h11);
        ce = 1'b1;
        rd_chk(8'h0f, 8'hac, 8'hfc);
        // generator stopped: no ticks at all
        cyc = 0;
        repeat (300) begin
            @(negedge clk);
            if (tick === 1'b1) cyc++;
        end
        check(8'(cyc), 8'h00);
        acc(1'b1, 8'h0f, 8'hab, 8'h43);
        rd_chk(8'h0f, 8'hab, 8'h43);
        wait_tick(70000);
        // tick period for every prescaler code, reload 0xfffc
        for (int i = 0; i < 4; i++) begin
            acc(1'b1, 8'h0f, 8'hab, 8'h40 | 8'(sels[i]));
            wait_tick(600);
            wait_tick(600);
            check(8'(cyc), 8'(divs[sels[i]] * 4));
        end
        // transmit one byte, sampled mid tick interval
        acc(1'b1, 8'h0f, 8'hab, 8'h43);
        wait_tick(600);
        acc(1'b1, 8'h00, 8'h99, 8'ha5);
        for (int k = 1; k < 20; k++) begin
            wait_tick(20);
            repeat (2) @(negedge clk);
            smp[k] = txd;
        end
        for (int i = 0; i < 8; i++) begin
            b0[i] = smp[2 + 2 * i];
            b1[i] = smp[3 + 2 * i];
        end
        check(b0, 8'ha5);
        check(b1, 8'ha5);
        check({6'h00, smp[1], smp[18]}, 8'h01);
        wait_tick(20);
        repeat (3) @(negedge clk);
        check({7'h00, busy}, 8'h00);
        rd_chk(8'h00, 8'h99, 8'h00);
        // receive a good frame, then one with a low stop bit
        ubg_remote_port_i.send(8'h3c, 1'b1);
        repeat (20) @(negedge clk);
        check(8'(nrx), 8'h01);
        rd_chk(8'h00, 8'h99, 8'h3c);
        ubg_remote_port_i.send(8'hc3, 1'b0);
        repeat (20) @(negedge clk);
        acc(1'b1, 8'h00, 8'h99, 8'h5a);
        rd_chk(8'h00, 8'h99, 8'h3c);
        check(8'(nrx), 8'h01);
        conclude();
    end
endmodule

`default_nettype wire
